// ---- ruc_ctrl.v ----
// register update and nvm transfer controller
// Operation
// (R1) update bit copies buffer into active registers
// (R2) update bit clears itself after copy
// (R3) segment list of start addresses and counts
// (R4) segment opcodes: update command, end marker
// (R5) default list moves all, then updates; the default list here moves only the one byte at 0x0ff
// (R6) busy bit reads 1 while transferring
// (R7) busy drives status pin when routed
// (R8) error flag set on bad transfer data
// (R9) soft reload from nvm when select low
// (R10) nvm writes blocked unless write enable set
// (R11) store bit starts buffer-to-nvm copy, self-clears
// (R12) host waits for busy low before commands
`timescale 1ns/1ps
`default_nettype none
`include "ruc_consts.vh"
module ruc_ctrl #(
    parameter AW = 12,
    parameter NVM_AW = 10
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [AW-1:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    input wire nvm_select_n_in,
    output wire update_active_out,
    output wire soft_reset_out,
    output reg [AW-1:0] buf_addr_out,
    output wire buf_wr_out,
    output reg [7:0] buf_wdata_out,
    input wire [7:0] buf_rdata_in,
    output reg [NVM_AW-1:0] nvm_addr_out,
    output wire nvm_wr_out,
    output wire nvm_rd_out,
    output reg [7:0] nvm_wdata_out,
    input wire [7:0] nvm_rdata_in,
    input wire nvm_data_bad_in,
    output wire status_pin_out
);
    localparam S_IDLE = 3'd0;
    localparam S_FETCH = 3'd1;
    localparam S_HDR0 = 3'd2;
    localparam S_HDR1 = 3'd3;
    localparam S_HDR2 = 3'd4;
    localparam S_MOVE = 3'd5;
    localparam S_RESET = 3'd6;

    reg [2:0] state;
    reg [2:0] next_state;
    reg busy;
    reg data_error;
    reg write_en;
    reg dir_store;
    reg reload_pending;
    reg [7:0] status_route;
    reg [4:0] seg_ptr;
    reg [7:0] seg_count;
    reg [7:0] hdr_byte;
    reg upd_pulse;
    reg move_phase;

    wire [7:0] seg_rdata;
    wire seg_wr;
    wire [4:0] seg_waddr;
    wire in_seg;
    wire [4:0] seg_rd_addr;
    wire hdr_walk;

    // decode of an address against a single register
    function hit;
        input [AW-1:0] a;
        input [AW-1:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    assign in_seg = (reg_addr_in >= `RUC_ADDR_SEG_FIRST) && (reg_addr_in <= `RUC_ADDR_SEG_LAST);
    assign seg_waddr = reg_addr_in[4:0] - 5'h00;
    // list is frozen while the controller walks it
    assign seg_wr = reg_wr_in && in_seg && !busy; // [R3]

    // read address runs one byte ahead while the header is parsed:
    // the list memory answers a clock late, so without the look-ahead
    // each header byte would be seen one state after it is needed
    // and the address fields would be taken from the wrong bytes
    assign hdr_walk = (state == S_HDR0) || (state == S_HDR1) || (state == S_HDR2);
    assign seg_rd_addr = hdr_walk ? (seg_ptr + 5'h01) : seg_ptr; // [R3]

    // list storage; the walker owns the read port, the host the write port
    ruc_seg_mem #(.DEPTH(`RUC_SEG_DEPTH), .AW(5)) u_seg (
        .ref_clk_in(ref_clk_in),
        .wr_en_in(seg_wr),
        .wr_addr_in(seg_waddr),
        .wr_data_in(reg_wdata_in),
        .rd_addr_in(seg_rd_addr),
        .rd_data_out(seg_rdata)
    );

    wire wr_update = reg_wr_in && hit(reg_addr_in, `RUC_ADDR_UPDATE)
        && reg_wdata_in[`RUC_BIT_UPDATE];
    wire wr_store = reg_wr_in && hit(reg_addr_in, `RUC_ADDR_STORE)
        && reg_wdata_in[`RUC_BIT_STORE];
    wire wr_reload = reg_wr_in && hit(reg_addr_in, `RUC_ADDR_RELOAD_WE)
        && reg_wdata_in[`RUC_BIT_RELOAD] && !nvm_select_n_in;

    // update pulse lasts one clock, so the command bit clears itself
    assign update_active_out = upd_pulse; // [R1] [R2]
    assign soft_reset_out = (state == S_RESET);
    assign status_pin_out = status_route[`RUC_BIT_STATUS_ROUTE] ? busy : 1'b0; // [R7]
    // store direction writes nvm only while write enable is set
    assign nvm_wr_out = (state == S_MOVE) && dir_store && move_phase && write_en; // [R10]
    assign nvm_rd_out = (state == S_MOVE) && !dir_store && !move_phase;
    assign buf_wr_out = (state == S_MOVE) && !dir_store && move_phase;

    // host-facing control registers
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_en <= 1'b0;
            status_route <= `RUC_STATUS_ROUTE_RESET;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, `RUC_ADDR_RELOAD_WE)) begin
                write_en <= reg_wdata_in[`RUC_BIT_WRITE_EN]; // [R10]
            end
            if (hit(reg_addr_in, `RUC_ADDR_STATUS_ROUTE)) begin
                status_route <= reg_wdata_in;
            end
        end
    end

    // next state of the segment walker
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (wr_store || wr_reload) begin
                    next_state = S_FETCH;
                end
            end
            S_FETCH: next_state = S_HDR0;
            S_HDR0: begin
                // opcodes are recognised in the first byte of an entry
                if (seg_rdata == `RUC_OP_END) begin // [R4]
                    next_state = reload_pending ? S_RESET : S_IDLE;
                end else if (seg_rdata == `RUC_OP_UPDATE) begin // [R4] [R5]
                    next_state = S_FETCH;
                end else begin
                    next_state = S_HDR1;
                end
            end
            S_HDR1: next_state = S_HDR2;
            S_HDR2: next_state = S_MOVE;
            S_MOVE: begin
                if (move_phase && seg_count == 8'h00) begin
                    next_state = S_FETCH;
                end
            end
            S_RESET: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // segment walker: entry = count byte, address high, address low
    // a segment moves count+1 bytes, two clocks per byte:
    // phase 0 captures both read sides, phase 1 strobes the write
    // and steps the addresses, so a write lands on the old address
    // nvm address is not reloaded per segment: the nvm image is packed
    // error flag is sticky within one transfer, cleared at the next start
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= S_IDLE;
            busy <= 1'b0;
            data_error <= 1'b0;
            dir_store <= 1'b0;
            reload_pending <= 1'b0;
            seg_ptr <= 5'h00;
            seg_count <= 8'h00;
            hdr_byte <= 8'h00;
            upd_pulse <= 1'b0;
            move_phase <= 1'b0;
            buf_addr_out <= {AW{1'b0}};
            buf_wdata_out <= 8'h00;
            nvm_addr_out <= {NVM_AW{1'b0}};
            nvm_wdata_out <= 8'h00;
        end else begin
            state <= next_state;
            upd_pulse <= wr_update;
            case (state)
                S_IDLE: begin
                    if (wr_store || wr_reload) begin
                        busy <= 1'b1; // [R6] [R11] [R9]
                        data_error <= 1'b0;
                        dir_store <= wr_store;
                        reload_pending <= wr_reload && !wr_store;
                        seg_ptr <= 5'h00;
                        nvm_addr_out <= {NVM_AW{1'b0}};
                    end
                end
                S_HDR0: begin
                    hdr_byte <= seg_rdata;
                    seg_ptr <= seg_ptr + 5'h01;
                    if (seg_rdata == `RUC_OP_UPDATE) begin
                        upd_pulse <= 1'b1; // [R4]
                    end
                    if (seg_rdata == `RUC_OP_END && !reload_pending) begin
                        busy <= 1'b0; // [R6] [R11]
                    end
                end
                S_HDR1: begin
                    seg_count <= hdr_byte;
                    buf_addr_out[AW-1:8] <= seg_rdata[AW-9:0];
                    seg_ptr <= seg_ptr + 5'h01;
                end
                S_HDR2: begin
                    buf_addr_out[7:0] <= seg_rdata;
                    seg_ptr <= seg_ptr + 5'h01;
                    move_phase <= 1'b0;
                end
                S_MOVE: begin
                    move_phase <= !move_phase;
                    if (!move_phase) begin
                        buf_wdata_out <= nvm_rdata_in;
                        nvm_wdata_out <= buf_rdata_in;
                    end else begin
                        // sticky until the next transfer starts
                        if (nvm_data_bad_in) begin
                            data_error <= 1'b1; // [R8]
                        end
                        seg_count <= seg_count - 8'h01;
                        buf_addr_out <= buf_addr_out + {{(AW-1){1'b0}}, 1'b1};
                        nvm_addr_out <= nvm_addr_out + {{(NVM_AW-1){1'b0}}, 1'b1};
                    end
                end
                S_RESET: begin
                    busy <= 1'b0;
                    reload_pending <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // register read mux; update and reload bits read back as zero, the store bit reads 1 while a store runs
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= `RUC_RESET_BYTE;
        end else if (reg_rd_in) begin
            if (hit(reg_addr_in, `RUC_ADDR_BUSY)) begin
                reg_rdata_out <= {7'h00, busy}; // [R6]
            end else if (hit(reg_addr_in, `RUC_ADDR_ERROR)) begin
                reg_rdata_out <= {7'h00, data_error}; // [R8]
            end else if (hit(reg_addr_in, `RUC_ADDR_RELOAD_WE)) begin
                reg_rdata_out <= {7'h00, write_en}; // [R9] [R10]
            end else if (hit(reg_addr_in, `RUC_ADDR_STORE)) begin
                reg_rdata_out <= {7'h00, busy && dir_store}; // [R11]
            end else if (hit(reg_addr_in, `RUC_ADDR_STATUS_ROUTE)) begin
                reg_rdata_out <= status_route;
            end else if (in_seg) begin
                reg_rdata_out <= 8'h00;
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end
endmodule // ruc_ctrl
`default_nettype wire

// ---- ruc_consts.vh ----
// register offsets, field positions, opcodes, list depth and reset values for the update/nvm controller
`ifndef RUC_CONSTS_VH
`define RUC_CONSTS_VH
`define RUC_ADDR_UPDATE 12'h232
`define RUC_ADDR_SEG_FIRST 12'ha00
`define RUC_ADDR_SEG_LAST 12'ha16
`define RUC_ADDR_BUSY 12'hb00
`define RUC_ADDR_ERROR 12'hb01
`define RUC_ADDR_RELOAD_WE 12'hb02
`define RUC_ADDR_STORE 12'hb03
`define RUC_ADDR_STATUS_ROUTE 12'h01d
`define RUC_BIT_UPDATE 0
`define RUC_BIT_BUSY 0
`define RUC_BIT_ERROR 0
`define RUC_BIT_WRITE_EN 0
`define RUC_BIT_RELOAD 1
`define RUC_BIT_STORE 0
`define RUC_BIT_STATUS_ROUTE 7
`define RUC_SEG_DEPTH 23
`define RUC_OP_UPDATE 8'h80
`define RUC_OP_END 8'hff
`define RUC_RESET_BYTE 8'h00
`define RUC_STATUS_ROUTE_RESET 8'h00
`endif

// ---- ruc_seg_mem.v ----
// segment list memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ruc_seg_mem #(
    parameter DEPTH = 23,
    parameter AW = 5
) (
    input wire ref_clk_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [7:0] wr_data_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [7:0] rd_data_out
);
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    // default list: one single-byte segment at address 0x0ff, then update op, then end
    initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] = 8'hff;
        end
        mem[0] = 8'h00;
        mem[1] = 8'h00;
        mem[2] = 8'hff;
        mem[3] = 8'h80;
        mem[4] = 8'hff;
    end

    // synchronous write and registered read
    always @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule // ruc_seg_mem
`default_nettype wire

// ---- ruc_mem_model.sv ----
// buffer bank and nonvolatile memory standing behind the controller
`timescale 1ns/1ps
`default_nettype none
module ruc_mem_model (
    input wire logic ref_clk_in,
    input wire logic [11:0] buf_addr_in,
    input wire logic buf_wr_in,
    input wire logic [7:0] buf_wdata_in,
    output logic [7:0] buf_rdata_out,
    input wire logic [9:0] nvm_addr_in,
    input wire logic nvm_wr_in,
    input wire logic [7:0] nvm_wdata_in,
    output logic [7:0] nvm_rdata_out
);
    logic [7:0] buf_mem [0:4095];
    logic [7:0] nvm_mem [0:1023];
    // combinational reads, as the controller expects
    assign buf_rdata_out = buf_mem[buf_addr_in];
    assign nvm_rdata_out = nvm_mem[nvm_addr_in];
    // blank bank, erased nvm, so a lost write shows as 8'hff
    initial begin
        foreach (buf_mem[i]) buf_mem[i] = 8'h00;
        foreach (nvm_mem[i]) nvm_mem[i] = 8'hff;
    end
    // writes land on the rising edge
    always @(posedge ref_clk_in) begin
        if (buf_wr_in) begin
            buf_mem[buf_addr_in] <= buf_wdata_in;
        end
        if (nvm_wr_in) begin
            nvm_mem[nvm_addr_in] <= nvm_wdata_in;
        end
    end
endmodule // ruc_mem_model
`default_nettype wire

// ---- ruc_ctrl_sva.sv ----
// port-level checks of the update/nvm controller
`timescale 1ns/1ps
`default_nettype none
module ruc_ctrl_sva #(
    parameter AW = 12
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire reg_wr_in,
    input wire [AW-1:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire nvm_select_n_in,
    input wire update_active_out,
    input wire soft_reset_out,
    input wire nvm_wr_out,
    input wire status_pin_out
);
    reg route_q;
    reg we_q;
    wire wr_upd = reg_wr_in && reg_addr_in == 12'h232 && reg_wdata_in[0];
    // shadow of status routing and write enable, seen only through writes
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            route_q <= 1'b0;
            we_q <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == 12'h01d) begin
            route_q <= reg_wdata_in[7];
        end else if (reg_wr_in && reg_addr_in == 12'hb02) begin
            we_q <= reg_wdata_in[0];
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    upd_pulse_a: assert property (wr_upd |=> update_active_out)
        else $error("no update pulse after update write");
    upd_clear_a: assert property (update_active_out && !wr_upd |=> !update_active_out)
        else $error("update pulse did not clear");
    route_off_a: assert property (!route_q |-> !status_pin_out)
        else $error("status pin driven while not routed");
    nvm_lock_a: assert property (!we_q |-> !nvm_wr_out)
        else $error("nvm write while protected");
    store_busy_a: assert property (route_q && !status_pin_out && reg_wr_in
        && reg_addr_in == 12'hb03 && reg_wdata_in[0] |-> ##[1:2] status_pin_out)
        else $error("store did not raise busy");
    reload_refuse_a: assert property (route_q && !status_pin_out && reg_wr_in
        && reg_addr_in == 12'hb02 && reg_wdata_in[1] && nvm_select_n_in
        |=> !status_pin_out [*2]) else $error("reload ran with select high");
    reload_pulse_a: assert property (soft_reset_out |=> !soft_reset_out)
        else $error("soft reset longer than one cycle");
    wr_busy_a: assert property (route_q && nvm_wr_out |-> status_pin_out)
        else $error("nvm write outside busy");
endmodule // ruc_ctrl_sva
`default_nettype wire

// ---- ruc_ctrl_tb.sv ----
// register-access sequences with expected values for the update/nvm controller
`timescale 1ns/1ps
`default_nettype none
module ruc_ctrl_tb;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel_n = 1'b1, bad = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] r;
    logic [7:0] seg [0:4] = '{8'h01, 8'h00, 8'h10, 8'h80, 8'hff};
    wire [7:0] rdata, b_rd, n_rd, b_wd, n_wd;
    wire [11:0] b_addr;
    wire [9:0] n_addr;
    wire upd, srst, b_wr, n_wr, pin;
    int n_mismatch = 0, samples_checked = 0, n_upd = 0, n_srst = 0, cycles = 0;
    always #20 clk = ~clk;
    ruc_ctrl dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .nvm_select_n_in(sel_n), .update_active_out(upd), .soft_reset_out(srst),
        .buf_addr_out(b_addr), .buf_wr_out(b_wr), .buf_wdata_out(b_wd), .buf_rdata_in(b_rd),
        .nvm_addr_out(n_addr), .nvm_wr_out(n_wr), .nvm_rd_out(), .nvm_wdata_out(n_wd),
        .nvm_rdata_in(n_rd), .nvm_data_bad_in(bad), .status_pin_out(pin));
    ruc_mem_model m_u (.ref_clk_in(clk), .buf_addr_in(b_addr), .buf_wr_in(b_wr),
        .buf_wdata_in(b_wd), .buf_rdata_out(b_rd), .nvm_addr_in(n_addr), .nvm_wr_in(n_wr),
        .nvm_wdata_in(n_wd), .nvm_rdata_out(n_rd));
    // pulse counters and a hang limit well above the hundred or so cycles needed
    always @(posedge clk) begin
        n_upd <= n_upd + upd;
        n_srst <= n_srst + srst;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe for one cycle, then a free cycle before the next request
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        r = rdata;
    endtask
    // poll busy under a bound; still busy after 300 reads counts as a mismatch
    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            rd_reg(12'hb00);
            if (r[0] === 1'b0) return;
        end
        chk(r, 8'h00);
    endtask
    task automatic go(input logic [11:0] a, input logic [7:0] d);
        wr_reg(a, d);
        rd_reg(12'hb00);
        chk(r, 8'h01);
        chk({7'h00, pin}, 8'h01);
        wait_idle();
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(12'hb02);
        chk(r, 8'h00);
        wr_reg(12'h232, 8'h01);
        rd_reg(12'h232);
        chk(r, 8'h00);
        chk(8'(n_upd), 8'h01);
        foreach (seg[i]) wr_reg(12'ha00 + 12'(i), seg[i]);
        wr_reg(12'h01d, 8'h80);
        m_u.buf_mem[16] = 8'ha5;
        m_u.buf_mem[17] = 8'h3c;
        go(12'hb03, 8'h01);
        r = 8'hff;
        foreach (m_u.nvm_mem[i]) r &= m_u.nvm_mem[i];
        chk(r, 8'hff);
        wr_reg(12'hb02, 8'h01);
        go(12'hb03, 8'h01);
        rd_reg(12'hb03);
        chk(r, 8'h00);
        rd_reg(12'hb01);
        chk(r, 8'h00);
        chk(8'(n_upd), 8'h03);
        m_u.buf_mem[16] = 8'h00;
        m_u.buf_mem[17] = 8'h00;
        wr_reg(12'hb02, 8'h03);
        rd_reg(12'hb00);
        chk(r, 8'h00);
        @(posedge clk);
        sel_n <= 1'b0;
        bad <= 1'b1;
        go(12'hb02, 8'h03);
        chk(m_u.buf_mem[16], 8'ha5);
        chk(m_u.buf_mem[17], 8'h3c);
        chk(8'(n_srst), 8'h01);
        rd_reg(12'hb02);
        chk(r, 8'h01);
        rd_reg(12'hb01);
        chk(r, 8'h01);
        @(posedge clk);
        bad <= 1'b0;
        go(12'hb03, 8'h01);
        rd_reg(12'hb01);
        chk(r, 8'h00);
        test_done();
    end
endmodule // ruc_ctrl_tb
bind ruc_ctrl ruc_ctrl_sva #(.AW(AW)) chk_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .nvm_select_n_in(nvm_select_n_in), .update_active_out(update_active_out),
    .soft_reset_out(soft_reset_out), .nvm_wr_out(nvm_wr_out), .status_pin_out(status_pin_out));
`default_nettype wire
